// File: verilog/pmc_top.sv
// Protocol multiplexing capability and channel control register bank
`timescale 1ns/1ps
`default_nettype none

`include "pmc_regs.svh"

module pmc_top #(
  parameter logic [5:0]  TABLE_SIZE = 6'h04,
  parameter logic [62:0] IMPL_MAP   = 63'h0000_0000_0000_000f,
  parameter logic [2:0]  MUX_RATES  = 3'h7,
  parameter logic [2:0]  LINK_RATES = 3'h7
) (
  // Clock and reset
  input  wire logic                  clock_in,
  input  wire logic                  rstn_in,
  // Configuration access
  input  wire pmc_pkg::pmc_cfg_req_t cfg_req_in,
  output pmc_pkg::pmc_cfg_rsp_t      cfg_rsp_out,
  // Link state
  input  wire logic                  link_layer_down_in,
  input  wire pmc_pkg::pmc_rate_t    link_rate_in,
  // Per-channel disable reasons from the protocols
  input  wire logic [3:0]            proto_rate_ok_in,
  input  wire logic [3:0]            width_dis_in,
  input  wire logic [3:0]            proto_dis_in,
  // Channel state towards the mux protocol layer
  output logic [3:0]                 channel_enable_out,
  output pmc_pkg::pmc_dis_t [3:0]    channel_disable_flags_out,
  // Transmit gating
  input  wire logic [3:0]            tx_req_in,
  output logic [3:0]                 tx_grant_out,
  // Receive filtering
  input  wire logic                  rx_valid_in,
  input  wire logic [1:0]            rx_chan_in,
  output logic                       rx_accept_out,
  output logic                       rx_drop_out
);
  import pmc_pkg::*;

  // Writable bits of a select: smallest all-ones cover of the size
  function automatic pmc_sel_t sel_mask(input pmc_sel_t size);
    pmc_sel_t m;
    m = 6'h00;
    for (int b = 0; b < `PMC_SEL_W; b++) begin
      if ((size >> b) != 6'h00) begin
        m[b] = 1'b1;
      end
    end
    return m;
  endfunction : sel_mask

  // Whether a rate is set in a three-bit rate map
  function automatic logic rate_in_map(input pmc_rate_t r, input logic [2:0] m);
    logic hit;
    case (r)
      PMC_RATE_2G5: hit = m[`PMC_RATE_25];
      PMC_RATE_5G0: hit = m[`PMC_RATE_50];
      PMC_RATE_8G0: hit = m[`PMC_RATE_80];
      default:      hit = 1'b0;
    endcase
    return hit;
  endfunction : rate_in_map

  // Fixed capability content
  localparam pmc_sel_t   SEL_MASK  = sel_mask(TABLE_SIZE);
  localparam logic [2:0] RATE_BOTH = MUX_RATES & LINK_RATES;

  logic [2:0]   rate_map;
  logic [31:0]  cap_word;

  // Control state
  pmc_sel_t [3:0] sel_r;
  pmc_sel_t [3:0] sel_nxt;

  // Access answer state
  logic         ack_r;
  logic         ack_nxt;
  logic [31:0]  rdata_r;
  logic [31:0]  rdata_nxt;

  // Channel state
  logic [3:0]   enable_r;
  logic [3:0]   enable_nxt;
  pmc_dis_t [3:0] flags_r;
  pmc_dis_t [3:0] flags_nxt;

  // Receive filter state
  logic         accept_r;
  logic         accept_nxt;
  logic         drop_r;
  logic         drop_nxt;

  // Evaluator outputs
  logic [3:0]     ev_enable;
  pmc_dis_t [3:0] ev_flags;
  logic           mux_rate_ok;
  logic [31:0]    ctrl_word;

  // Rate bitmap limited to link rates, 2.5 GT/s kept if empty
  assign rate_map = (RATE_BOTH != 3'h0) ? RATE_BOTH
                                        : `PMC_RATE_FALLBACK;

  // Capability word, reserved bits zero
  always_comb begin
    cap_word = 32'h0000_0000;
    cap_word[`PMC_SIZE_LSB +: `PMC_SIZE_W] = TABLE_SIZE;
    cap_word[`PMC_RATE_LSB +: `PMC_RATE_W] = rate_map;
  end

  // Control word view, gaps read as zero
  always_comb begin
    ctrl_word = 32'h0000_0000;
    for (int c = 0; c < `PMC_NCH; c++) begin
      ctrl_word[c*`PMC_CH_STRIDE +: `PMC_SEL_W] = sel_r[c];
    end
  end

  // Select writes per byte lane, masked to the all-ones cover of the table size
  always_comb begin
    sel_nxt = sel_r;
    if (cfg_req_in.valid && cfg_req_in.write
        && (cfg_req_in.addr == `PMC_CTRL_OFS)) begin
      for (int c = 0; c < `PMC_NCH; c++) begin
        if (cfg_req_in.be[c]) begin
          sel_nxt[c] = cfg_req_in.wdata[c*`PMC_CH_STRIDE +: `PMC_SEL_W]
                     & SEL_MASK;
        end
      end
    end
  end

  // Select registers
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sel_r <= 24'(`PMC_CTRL_RST);
    end else begin
      sel_r <= sel_nxt;
    end
  end

  // Read data and acknowledge, one cycle after the request
  always_comb begin
    ack_nxt   = cfg_req_in.valid;
    rdata_nxt = 32'h0000_0000;
    if (cfg_req_in.valid && !cfg_req_in.write) begin
      case (cfg_req_in.addr)
        `PMC_CAP_OFS:  rdata_nxt = cap_word;
        `PMC_CTRL_OFS: rdata_nxt = ctrl_word;
        default:       rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Answer registers
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign cfg_rsp_out.ack   = ack_r;
  assign cfg_rsp_out.rdata = rdata_r;

  // Current rate must be set in the capability rate bitmap (mux rates limited to link rates)
  assign mux_rate_ok = rate_in_map(link_rate_in, rate_map);

  // One evaluator per channel
  for (genvar c = 0; c < `PMC_NCH; c++) begin : g_chan
    pmc_chan_eval u_eval (
      .sel_in           (sel_r[c]),
      .table_size_in    (TABLE_SIZE),
      .impl_map_in      (IMPL_MAP),
      .mux_rate_ok_in   (mux_rate_ok),
      .proto_rate_ok_in (proto_rate_ok_in[c]),
      .width_dis_in     (width_dis_in[c]),
      .proto_dis_in     (proto_dis_in[c]),
      .flags_out        (ev_flags[c]),
      .enable_out       (ev_enable[c])
    );
  end

  // Enables follow current selects and flags, dropped on link down
  always_comb begin
    flags_nxt  = ev_flags;
    enable_nxt = ev_enable;
    if (link_layer_down_in) begin
      enable_nxt = 4'h0;
    end
  end

  // Channel state registers
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      enable_r <= 4'h0;
      flags_r  <= '0;
    end else begin
      enable_r <= enable_nxt;
      flags_r  <= flags_nxt;
    end
  end

  assign channel_enable_out        = enable_r;
  assign channel_disable_flags_out = flags_r;

  // Transmit only on enabled channels while the link is up
  assign tx_grant_out = tx_req_in & enable_r
                      & {4{~link_layer_down_in}};

  // Receive filter: packets on disabled channels are dropped
  always_comb begin
    accept_nxt = 1'b0;
    drop_nxt   = 1'b0;
    if (rx_valid_in) begin
      if (enable_r[rx_chan_in] && !link_layer_down_in) begin
        accept_nxt = 1'b1;
      end else begin
        drop_nxt = 1'b1;
      end
    end
  end

  // Receive filter registers
  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      accept_r <= 1'b0;
      drop_r   <= 1'b0;
    end else begin
      accept_r <= accept_nxt;
      drop_r   <= drop_nxt;
    end
  end

  assign rx_accept_out = accept_r;
  assign rx_drop_out   = drop_r;

endmodule : pmc_top

`default_nettype wire

// File: verilog/pmc_regs.svh
// Offsets, field positions, reset values and widths of the mux channel registers
`ifndef PMC_REGS_SVH
`define PMC_REGS_SVH

// Register offsets within the capability structure (byte addresses)
`define PMC_CAP_OFS      8'h04
`define PMC_CTRL_OFS     8'h08

// Capability word fields
`define PMC_SIZE_LSB     0
`define PMC_SIZE_W       6
`define PMC_RATE_LSB     8
`define PMC_RATE_W       3

// Rate bitmap positions relative to the rate field
`define PMC_RATE_25      0
`define PMC_RATE_50      1
`define PMC_RATE_80      2
`define PMC_RATE_FALLBACK 3'h1

// Control word fields: one select per byte lane, low six bits
`define PMC_NCH          4
`define PMC_SEL_W        6
`define PMC_CH_STRIDE    8
`define PMC_TABLE_MAX    63
`define PMC_CTRL_RST     32'h0000_0000

`endif

// File: verilog/pmc_pkg.sv
// Types shared by the mux channel register bank
package pmc_pkg;

  // Link rate currently in use
  typedef enum logic [1:0] {
    PMC_RATE_2G5,
    PMC_RATE_5G0,
    PMC_RATE_8G0
  } pmc_rate_t;

  // Protocol table index held in a channel select field
  typedef logic [5:0] pmc_sel_t;

  // Configuration access request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  addr;
    logic [3:0]  be;
    logic [31:0] wdata;
  } pmc_cfg_req_t;

  // Configuration access answer
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } pmc_cfg_rsp_t;

  // Disable flags of one channel
  typedef struct packed {
    logic proto;
    logic width;
    logic rate;
  } pmc_dis_t;

endpackage : pmc_pkg

// File: verilog/pmc_chan_eval.sv
// Per-channel enable decision from select, table size and disable reasons
`timescale 1ns/1ps
`default_nettype none

module pmc_chan_eval (
  // Channel configuration
  input  wire pmc_pkg::pmc_sel_t sel_in,
  input  wire pmc_pkg::pmc_sel_t table_size_in,
  input  wire logic [62:0]       impl_map_in,
  // Disable reasons
  input  wire logic              mux_rate_ok_in,
  input  wire logic              proto_rate_ok_in,
  input  wire logic              width_dis_in,
  input  wire logic              proto_dis_in,
  // Decision
  output pmc_pkg::pmc_dis_t      flags_out,
  output logic                   enable_out
);
  import pmc_pkg::*;

  logic     assigned;
  logic     in_range;
  logic     implemented;
  pmc_sel_t entry_idx;

  // Zero select means nothing assigned; otherwise it is a table index
  assign assigned    = (sel_in != 6'h00);
  assign in_range    = (sel_in <= table_size_in);
  assign entry_idx   = sel_in - 6'h01;
  assign implemented = assigned & impl_map_in[entry_idx];

  // Flags stay clear while no protocol is assigned
  assign flags_out.rate  = assigned & ~(mux_rate_ok_in & proto_rate_ok_in);
  assign flags_out.width = assigned & width_dis_in;
  assign flags_out.proto = assigned & proto_dis_in;

  // All three checks pass and no disable reason stands
  assign enable_out = assigned & in_range & implemented
                    & (flags_out == 3'h0);

endmodule : pmc_chan_eval

`default_nettype wire

// File: verif/pmc_top_checker.sv
// Port assertions for the mux channel register bank
`timescale 1ns/1ps
`default_nettype none

module pmc_top_checker #(
  parameter logic [5:0] TABLE_SIZE = 6'h04
) (
  // Clock and reset
  input wire logic                   clock_in,
  input wire logic                   rstn_in,
  // Configuration access
  input wire pmc_pkg::pmc_cfg_req_t  cfg_req_in,
  input wire pmc_pkg::pmc_cfg_rsp_t  cfg_rsp_out,
  // Link state and disable reasons
  input wire logic                   link_layer_down_in,
  input wire pmc_pkg::pmc_rate_t     link_rate_in,
  input wire logic [3:0]             width_dis_in,
  input wire logic [3:0]             proto_dis_in,
  // Channel state, transmit and receive
  input wire logic [3:0]             channel_enable_out,
  input wire pmc_pkg::pmc_dis_t [3:0] channel_disable_flags_out,
  input wire logic [3:0]             tx_req_in,
  input wire logic [3:0]             tx_grant_out,
  input wire logic                   rx_valid_in,
  input wire logic [1:0]             rx_chan_in,
  input wire logic                   rx_accept_out,
  input wire logic                   rx_drop_out
);
  import pmc_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  logic       rx_ok;
  logic [3:0] flag_any;
  logic [3:0] dis_any;

  // Expected receive verdict and per-channel flag summaries
  always_comb begin
    rx_ok = channel_enable_out[rx_chan_in] && !link_layer_down_in;
    dis_any = width_dis_in | proto_dis_in;
    for (int c = 0; c < 4; c++) begin
      flag_any[c] = |channel_disable_flags_out[c];
    end
  end

  property p_ack;
    1 |=> cfg_rsp_out.ack == $past(cfg_req_in.valid);
  endproperty
  a_ack: assert property (p_ack) else $error("ack does not follow request");
  property p_cap;
    cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.addr == 8'h04 |=>
      cfg_rsp_out.rdata[5:0] == TABLE_SIZE && cfg_rsp_out.rdata[7:6] == 2'h0 &&
      cfg_rsp_out.rdata[10:8] != 3'h0 && cfg_rsp_out.rdata[31:11] == 21'h0;
  endproperty
  a_cap: assert property (p_cap) else $error("capability word wrong");
  property p_gap;
    cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.addr == 8'h08 |=>
      (cfg_rsp_out.rdata & 32'hc0c0_c0c0) == 32'h0;
  endproperty
  a_gap: assert property (p_gap) else $error("control gap bits set");
  property p_grant;
    tx_grant_out == (tx_req_in & channel_enable_out & {4{!link_layer_down_in}});
  endproperty
  a_grant: assert property (p_grant) else $error("grant on idle channel");
  property p_down;
    link_layer_down_in |=> channel_enable_out == 4'h0;
  endproperty
  a_down: assert property (p_down) else $error("enable while link down");
  property p_rx;
    rx_valid_in |=> rx_accept_out == $past(rx_ok) && rx_drop_out == !$past(rx_ok);
  endproperty
  a_rx: assert property (p_rx) else $error("receive verdict wrong");
  property p_flag_en;
    (channel_enable_out & flag_any) == 4'h0;
  endproperty
  a_flag_en: assert property (p_flag_en) else $error("enable with flag set");
  property p_dis;
    |dis_any |=> (channel_enable_out & $past(dis_any)) == 4'h0;
  endproperty
  a_dis: assert property (p_dis) else $error("enable despite disable input");
  property p_rate;
    link_rate_in == 2'h3 |=> channel_enable_out == 4'h0;
  endproperty
  a_rate: assert property (p_rate) else $error("enable at unsupported rate");

  // Main scenarios reached
  c_accept: cover property (rx_accept_out);
  c_grant: cover property (|tx_grant_out);
  c_flags: cover property (|flag_any);
endmodule : pmc_top_checker

bind pmc_top pmc_top_checker #(.TABLE_SIZE(TABLE_SIZE)) u_chk (
  .clock_in, .rstn_in, .cfg_req_in, .cfg_rsp_out, .link_layer_down_in, .link_rate_in,
  .width_dis_in, .proto_dis_in, .channel_enable_out, .channel_disable_flags_out,
  .tx_req_in, .tx_grant_out, .rx_valid_in, .rx_chan_in, .rx_accept_out, .rx_drop_out
);

`default_nettype wire

// File: verif/tb_pmc_top.sv
// Self-checking bench for the mux channel register bank
`timescale 1ns/1ps
`default_nettype none

module tb_pmc_top;
  import pmc_pkg::*;
  logic              clock_in = 1'b0;
  logic              rstn_in, link_layer_down_in, rx_valid_in, acc, drop, acc0, drop0;
  pmc_cfg_req_t      cfg_req_in;
  pmc_cfg_rsp_t      rsp, rsp0;
  pmc_rate_t         link_rate_in;
  logic [3:0]        proto_rate_ok_in, width_dis_in, proto_dis_in, tx_req_in, en, en0, grant;
  pmc_dis_t [3:0]    flags;
  logic [1:0]        rx_chan_in;
  logic [31:0]       rd, rd0;
  int                errors = 0, checked = 0, cycles = 0;

  // Entries 1..3 implemented, link runs at 2.5 and 5.0 only
  pmc_top #(.IMPL_MAP(63'h0000_0000_0000_0007), .LINK_RATES(3'h3)) uut (
    .clock_in, .rstn_in, .cfg_req_in, .cfg_rsp_out(rsp), .link_layer_down_in, .link_rate_in,
    .proto_rate_ok_in, .width_dis_in, .proto_dis_in, .channel_enable_out(en),
    .channel_disable_flags_out(flags), .tx_req_in, .tx_grant_out(grant), .rx_valid_in,
    .rx_chan_in, .rx_accept_out(acc), .rx_drop_out(drop));
  // Empty protocol table twin on the same inputs
  pmc_top #(.TABLE_SIZE(6'h00)) uut_empty (
    .clock_in, .rstn_in, .cfg_req_in, .cfg_rsp_out(rsp0), .link_layer_down_in, .link_rate_in,
    .proto_rate_ok_in, .width_dis_in, .proto_dis_in, .channel_enable_out(en0),
    .channel_disable_flags_out(), .tx_req_in, .tx_grant_out(), .rx_valid_in,
    .rx_chan_in, .rx_accept_out(acc0), .rx_drop_out(drop0));

  // Clock and hang guard
  always #12.5 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : tick

  // One access: request for one edge, answer taken the cycle after
  task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    cfg_req_in = '{1'b1, wr, a, be, d};
    tick(1);
    check("ack", 32'(rsp.ack), 32'h1);
    rd = rsp.rdata;
    rd0 = rsp0.rdata;
    cfg_req_in.valid = 1'b0;
    tick(1);
  endtask : cfg

  // One received packet and its verdict on both banks
  task automatic rx(input logic [1:0] ch, input logic ok);
    rx_valid_in = 1'b1;
    rx_chan_in = ch;
    tick(1);
    rx_valid_in = 1'b0;
    check("accept", 32'(acc), 32'(ok));
    check("drop", 32'(drop), 32'(!ok));
    check("drop_empty", 32'(drop0) & ~32'(acc0), 32'h1);
    tick(1);
  endtask : rx

  // Main sequence
  initial begin
    cfg_req_in = '0;
    {link_layer_down_in, rx_valid_in, rx_chan_in} = '0;
    {width_dis_in, proto_dis_in, tx_req_in} = '0;
    link_rate_in = PMC_RATE_2G5;
    proto_rate_ok_in = 4'hf;
    rstn_in = 1'b0;
    repeat (6) @(posedge clock_in);
    #1 rstn_in = 1'b1;
    tick(1);
    check("en_reset", 32'(en), 32'h0);
    cfg(1'b0, 8'h08, 4'hf, 32'h0);
    check("ctrl_reset", rd, 32'h0);
    cfg(1'b1, 8'h04, 4'hf, 32'hffff_ffff);
    cfg(1'b0, 8'h04, 4'hf, 32'h0);
    check("cap", rd, 32'h0000_0304);
    check("cap_empty", rd0, 32'h0000_0700);
    cfg(1'b0, 8'h10, 4'hf, 32'h0);
    check("unmapped", rd, 32'h0);
    cfg(1'b1, 8'h08, 4'hf, 32'hffff_ffff);
    check("en_range", 32'(en), 32'h0);
    cfg(1'b0, 8'h08, 4'hf, 32'h0);
    check("ctrl_mask", rd, 32'h0707_0707);
    cfg(1'b1, 8'h08, 4'hf, 32'h0004_0301);
    check("en_sel", 32'(en), 32'h3);
    cfg(1'b1, 8'h08, 4'h1, 32'hffff_ff02);
    cfg(1'b0, 8'h08, 4'hf, 32'h0);
    check("ctrl_lane", rd, 32'h0004_0302);
    check("ctrl_empty", rd0, 32'h0);
    check("en_empty", 32'(en0), 32'h0);
    width_dis_in = 4'h9;
    tick(1);
    check("flags_w", 32'(flags), 32'h0000_0002);
    check("en_w", 32'(en), 32'h2);
    width_dis_in = 4'h0;
    proto_dis_in = 4'h2;
    tick(1);
    check("flags_p", 32'(flags), 32'h0000_0020);
    check("en_p", 32'(en), 32'h1);
    proto_dis_in = 4'h0;
    for (int i = 0; i < 4; i++) begin
      link_rate_in = pmc_rate_t'(i);
      tick(1);
      check("rate_en", 32'(en), (i < 2) ? 32'h3 : 32'h0);
      check("rate_flags", 32'(flags), (i < 2) ? 32'h0 : 32'h0000_0049);
    end
    link_rate_in = PMC_RATE_2G5;
    proto_rate_ok_in = 4'he;
    tick(1);
    check("flags_prate", 32'(flags), 32'h1);
    proto_rate_ok_in = 4'hf;
    tx_req_in = 4'hf;
    tick(1);
    check("grant", 32'(grant), 32'h3);
    link_layer_down_in = 1'b1;
    tick(0);
    check("grant_down", 32'(grant), 32'h0);
    tick(1);
    check("en_down", 32'(en), 32'h0);
    rx(2'h0, 1'b0);
    link_layer_down_in = 1'b0;
    tick(1);
    rx(2'h1, 1'b1);
    rx(2'h2, 1'b0);
    stop_test();
  end
endmodule : tb_pmc_top

`default_nettype wire
